//--- core/asc_scan_ctrl.sv
// Scan sequencer, registers and interrupt of a 24-channel converter controller
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "asc_map.svh"
module asc_scan_ctrl (
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [31:0]          wr_data_i,
    input  wire logic                 wr_en_i,
    input  wire logic                 rd_en_i,
    output logic      [31:0]          rd_data_o,
    input  wire logic                 hw_trig_i,
    output logic                      conv_start_o,
    output asc_pkg::asc_chan_t        conv_chan_o,
    input  wire logic                 conv_done_i,
    input  wire logic [11:0]          conv_data_i,
    output logic                      irq_o
);
    asc_res_if mif ();

    asc_pkg::asc_state_t state;
    asc_pkg::asc_mode_t  mode;
    logic                conversion_start_bit;
    logic                scan_end_irq_enable;
    logic                hw_trigger_enable;
    logic                result_alignment_select;
    logic [23:0]         chan_sel;
    logic                scan_flag;
    logic [2:0]          trig_sync;
    logic [5:0]          first_hit;
    logic [5:0]          next_hit;
    logic                trig_edge;
    logic                scan_end;
    logic                wr_ctrl;
    logic                wr_clr;
    logic                wr_ien;
    logic                rd_res_hit;
    logic [7:0]          res_off;
    logic                single_empty;

    // Lowest selected channel at or above a start index, with a found flag on top
    function automatic logic [5:0] asc_find(input logic [23:0] mask,
                                            input logic [4:0]  from);
        logic [5:0] hit;
        hit = 6'h00;
        for (int i = `ASC_NUM_CH - 1; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from)) begin
                hit = {1'b1, 5'(i)};
            end
        end
        return hit;
    endfunction : asc_find

    // Write strobes per register
    assign wr_ctrl = wr_en_i && (addr_i == `ASC_OFF_CTRL);
    assign wr_clr  = wr_en_i && (addr_i == `ASC_OFF_CLR);
    assign wr_ien  = wr_en_i && (addr_i == `ASC_OFF_IEN);

    // Channel search from the bottom and from just above the channel in flight
    assign first_hit = asc_find(chan_sel, 5'h00);
    assign next_hit  = asc_find(chan_sel, 5'(conv_chan_o + 5'h01));

    // Pin trigger passes two flops; the edge is taken between the second and third
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            trig_sync <= 3'h0;
        end else begin
            trig_sync <= {trig_sync[1:0], hw_trig_i};
        end
    end
    assign trig_edge = trig_sync[1] && !trig_sync[2];

    // Last conversion of a live scan; an aborted scan never gets here
    assign scan_end = (state == asc_pkg::ASC_CONV) && conversion_start_bit
                      && conv_done_i && !next_hit[5];
    // Single scan with nothing selected finishes at once rather than hang busy
    assign single_empty = (state == asc_pkg::ASC_IDLE) && conversion_start_bit
                          && !first_hit[5] && (mode != asc_pkg::ASC_CONT);

    // Configuration fields; mode is written as a whole field
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mode                    <= asc_pkg::ASC_SINGLE;
            hw_trigger_enable       <= 1'b0;
            result_alignment_select <= 1'b0;
        end else if (wr_ctrl) begin
            mode <= asc_pkg::asc_mode_t'(wr_data_i[`ASC_BIT_MODE_HI:`ASC_BIT_MODE_LO]);
            hw_trigger_enable       <= wr_data_i[`ASC_BIT_HW_TRIGGER_ENABLE];
            result_alignment_select <= wr_data_i[`ASC_BIT_ALIGN];
        end
    end

    // Interrupt enable is one flop seen in both the control and enable registers
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            scan_end_irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            scan_end_irq_enable <= wr_data_i[`ASC_BIT_IEN];
        end else if (wr_ien) begin
            scan_end_irq_enable <= wr_data_i[`ASC_BIT_SCANEND];
        end
    end

    // Channel select, one bit per analog input
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            chan_sel <= `ASC_RST_CHSEL;
        end else if (wr_en_i && (addr_i == `ASC_OFF_CHSEL_LO)) begin
            chan_sel[15:0] <= wr_data_i[15:0];
        end else if (wr_en_i && (addr_i == `ASC_OFF_CHSEL_HI)) begin
            chan_sel[23:16] <= wr_data_i[7:0];
        end
    end

    // Start bit: software write first, then gated trigger, then self-clear
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            conversion_start_bit <= 1'b0;
        end else if (wr_ctrl) begin
            conversion_start_bit <= wr_data_i[`ASC_BIT_START];
        end else if (trig_edge && hw_trigger_enable) begin
            conversion_start_bit <= 1'b1;
        end else if ((scan_end && (mode != asc_pkg::ASC_CONT)) || single_empty) begin
            conversion_start_bit <= 1'b0;
        end
    end

    // Sequencer; it rereads the live select mask at each step
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state        <= asc_pkg::ASC_IDLE;
            conv_start_o <= 1'b0;
            conv_chan_o  <= 5'h00;
        end else begin
            conv_start_o <= 1'b0;
            unique case (state)
                asc_pkg::ASC_IDLE: begin
                    if (conversion_start_bit && first_hit[5]) begin
                        conv_chan_o  <= first_hit[4:0];
                        conv_start_o <= 1'b1;
                        state        <= asc_pkg::ASC_CONV;
                    end
                end
                asc_pkg::ASC_CONV: begin
                    if (!conversion_start_bit) begin
                        state <= asc_pkg::ASC_IDLE;
                    end else if (conv_done_i) begin
                        if (next_hit[5]) begin
                            conv_chan_o  <= next_hit[4:0];
                            conv_start_o <= 1'b1;
                        end else if ((mode == asc_pkg::ASC_CONT) && first_hit[5]) begin
                            conv_chan_o  <= first_hit[4:0];
                            conv_start_o <= 1'b1;
                        end else begin
                            state <= asc_pkg::ASC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Result store, aligned as selected at the time of the write
    assign mif.wr_en   = (state == asc_pkg::ASC_CONV) && conversion_start_bit
                         && conv_done_i;
    assign mif.wr_idx  = conv_chan_o;
    assign mif.wr_data = result_alignment_select ? {conv_data_i, 4'h0}
                                                 : {4'h0, conv_data_i};

    // Scan-end flag; a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            scan_flag <= 1'b0;
        end else if (scan_end) begin
            scan_flag <= 1'b1;
        end else if (wr_clr && wr_data_i[`ASC_BIT_SCANEND]) begin
            scan_flag <= 1'b0;
        end
    end

    // Level interrupt, registered so the pin is glitch free
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= scan_flag && scan_end_irq_enable;
        end
    end

    // Read decode; unmapped and write-only addresses read as zero
    assign res_off    = addr_i - `ASC_OFF_RES_BASE;
    assign rd_res_hit = (addr_i >= `ASC_OFF_RES_BASE) && (addr_i <= `ASC_OFF_RES_LAST)
                        && (addr_i[1:0] == 2'b00);
    assign mif.rd_en  = rd_en_i;
    assign mif.rd_res = rd_res_hit;
    assign mif.rd_idx = res_off[6:2];

    always_comb begin
        mif.reg_rdata = 32'h0000_0000;
        unique case (addr_i)
            `ASC_OFF_CTRL: begin
                mif.reg_rdata[`ASC_BIT_START] = conversion_start_bit;
                mif.reg_rdata[`ASC_BIT_IEN]   = scan_end_irq_enable;
                mif.reg_rdata[`ASC_BIT_MODE_HI:`ASC_BIT_MODE_LO] = mode;
                mif.reg_rdata[`ASC_BIT_HW_TRIGGER_ENABLE]  = hw_trigger_enable;
                mif.reg_rdata[`ASC_BIT_ALIGN] = result_alignment_select;
                mif.reg_rdata[`ASC_BIT_BUSY]  = (state == asc_pkg::ASC_CONV);
            end
            `ASC_OFF_CHSEL_LO: mif.reg_rdata[15:0] = chan_sel[15:0];
            `ASC_OFF_CHSEL_HI: mif.reg_rdata[7:0]  = chan_sel[23:16];
            `ASC_OFF_STAT:     mif.reg_rdata[`ASC_BIT_SCANEND] = scan_flag;
            `ASC_OFF_IEN:      mif.reg_rdata[`ASC_BIT_SCANEND] = scan_end_irq_enable;
            default:           mif.reg_rdata = 32'h0000_0000;
        endcase
    end

    // Read data stands in the cycle after the strobe
    assign rd_data_o = mif.rdata;

    asc_res_mem u_res_mem (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .port      (mif.mem)
    );

    // Checks on the sequencer and flag behaviour
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_halt;
        (state == asc_pkg::ASC_CONV) && !conversion_start_bit
        ##1 (state == asc_pkg::ASC_IDLE);
    endsequence

    sequence s_launch;
        (state == asc_pkg::ASC_IDLE) && conversion_start_bit && first_hit[5];
    endsequence

    first_channel_a: assert property (
        s_launch |=> conv_start_o && (conv_chan_o == $past(first_hit[4:0])))
        else $error("scan did not open at the lowest selected channel");

    store_align_a: assert property (
        mif.wr_en |-> (result_alignment_select ? (mif.wr_data[3:0] == 4'h0)
                                                : (mif.wr_data[15:12] == 4'h0)))
        else $error("result stored with wrong alignment");

    store_target_a: assert property (
        mif.wr_en |-> (mif.wr_idx == conv_chan_o) && chan_sel[conv_chan_o])
        else $error("result written to a channel not in flight");

    scan_end_irq_a: assert property (
        scan_end ##1 scan_end_irq_enable |=> irq_o)
        else $error("enabled scan end raised no interrupt");

    irq_gate_a: assert property (
        !scan_end_irq_enable |=> !irq_o)
        else $error("interrupt shown while disabled");

    rescan_a: assert property (
        scan_end && (mode == asc_pkg::ASC_CONT) && first_hit[5] && !wr_ctrl |=>
        conv_start_o && (conv_chan_o == $past(first_hit[4:0])) && conversion_start_bit)
        else $error("continuous scan did not restart at the lowest channel");

    halt_restart_a: assert property (
        s_halt ##0 !conversion_start_bit |=> !conv_start_o && (state == asc_pkg::ASC_IDLE))
        else $error("conversion went on after the start bit was cleared");

    restart_low_a: assert property (
        s_halt ##[1:1000] s_launch |=> (conv_chan_o == $past(first_hit[4:0])))
        else $error("restart did not begin from the lowest channel");

    chan_legal_a: assert property (
        conv_start_o |-> (conv_chan_o < 5'h18) && chan_sel[conv_chan_o])
        else $error("unselected or out of range channel converted");

    trig_gate_a: assert property (
        trig_edge && !hw_trigger_enable && !wr_ctrl && !conversion_start_bit
        |=> !conversion_start_bit)
        else $error("trigger started conversion while disabled");

    single_clear_a: assert property (
        scan_end && (mode != asc_pkg::ASC_CONT) && !wr_ctrl && !(trig_edge && hw_trigger_enable)
        |=> !conversion_start_bit ##1 (state == asc_pkg::ASC_IDLE))
        else $error("single scan start bit did not self clear");

    abort_noflag_a: assert property (
        (state == asc_pkg::ASC_CONV) && !conversion_start_bit && !scan_flag |=> !scan_flag)
        else $error("aborted scan set the scan-end flag");

    flag_set_wins_a: assert property (
        scan_end && wr_clr && wr_data_i[`ASC_BIT_SCANEND] |=> scan_flag)
        else $error("scan end lost to a same-cycle clear");

    // Scan end latches the flag on the next edge, whatever the enable says
    scan_flag_set_a: assert property (
        scan_end |=> scan_flag)
        else $error("scan end did not set the flag");

    // A mid-scan step goes to the next higher selected channel, never back down
    sequence s_step;
        (state == asc_pkg::ASC_CONV) && conversion_start_bit && conv_done_i && next_hit[5];
    endsequence

    next_channel_a: assert property (
        s_step |=> conv_start_o && (conv_chan_o == $past(next_hit[4:0]))
                   && (conv_chan_o > $past(conv_chan_o)))
        else $error("scan did not step to the next selected channel");

    // Busy scan keeps its start bit until the last channel is stored
    start_held_a: assert property (
        (state == asc_pkg::ASC_CONV) && conversion_start_bit && !scan_end && !wr_ctrl
        |=> conversion_start_bit)
        else $error("start bit dropped while a scan was still running");

    // Each select half follows its own write, bit for bit
    chsel_low_a: assert property (
        wr_en_i && (addr_i == `ASC_OFF_CHSEL_LO)
        |=> (chan_sel[15:0] == $past(wr_data_i[15:0])))
        else $error("low channel select did not take the written bits");

    chsel_high_a: assert property (
        wr_en_i && (addr_i == `ASC_OFF_CHSEL_HI)
        |=> (chan_sel[23:16] == $past(wr_data_i[7:0])))
        else $error("high channel select did not take the written bits");

    // A clear works whenever no scan ends in the same cycle
    flag_clear_a: assert property (
        wr_clr && wr_data_i[`ASC_BIT_SCANEND] && !scan_end |=> !scan_flag)
        else $error("scan-end flag did not clear");
endmodule : asc_scan_ctrl

//--- core/asc_map.svh
// Register offsets, field positions, reset values and counts of the scan controller
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

`define ASC_OFF_CTRL     8'h00
`define ASC_OFF_CHSEL_LO 8'h04
`define ASC_OFF_CHSEL_HI 8'h08
`define ASC_OFF_STAT     8'h0c
`define ASC_OFF_CLR      8'h10
`define ASC_OFF_IEN      8'h14
`define ASC_OFF_RES_BASE 8'h40
`define ASC_OFF_RES_LAST 8'h9c

`define ASC_BIT_START    0
`define ASC_BIT_IEN      1
`define ASC_BIT_MODE_LO  2
`define ASC_BIT_MODE_HI  3
`define ASC_BIT_HW_TRIGGER_ENABLE     4
`define ASC_BIT_ALIGN    5
`define ASC_BIT_BUSY     6
`define ASC_BIT_SCANEND  0

`define ASC_RST_CTRL     32'h0000_0000
`define ASC_RST_CHSEL    24'h00_0000
`define ASC_RST_RES      16'h0000

`define ASC_NUM_CH       24
`define ASC_RES_BITS     12

`endif

//--- core/asc_pkg.sv
// Types shared by the scan controller files
package asc_pkg;
    typedef enum logic [0:0] {
        ASC_IDLE = 1'b0,
        ASC_CONV = 1'b1
    } asc_state_t;

    typedef enum logic [1:0] {
        ASC_SINGLE = 2'b00,
        ASC_GROUP  = 2'b01,
        ASC_CONT   = 2'b10,
        ASC_RSVD   = 2'b11
    } asc_mode_t;

    typedef logic [4:0]  asc_chan_t;
    typedef logic [15:0] asc_res_t;
endpackage : asc_pkg

//--- core/asc_res_if.sv
// Result store port between the sequencer and the result memory
`timescale 1ns/10ps
interface asc_res_if;
    logic              wr_en;
    asc_pkg::asc_chan_t wr_idx;
    asc_pkg::asc_res_t  wr_data;
    logic              rd_en;
    logic              rd_res;
    asc_pkg::asc_chan_t rd_idx;
    logic [31:0]       reg_rdata;
    logic [31:0]       rdata;

    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_res, rd_idx, reg_rdata,
                  input rdata);
    modport mem  (input wr_en, wr_idx, wr_data, rd_en, rd_res, rd_idx, reg_rdata,
                  output rdata);
endinterface : asc_res_if

//--- core/asc_res_mem.sv
// Per-channel result memory with the registered read-data word of the register port
`timescale 1ns/10ps
`include "asc_map.svh"
module asc_res_mem (
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    asc_res_if.mem    port
);
    asc_pkg::asc_res_t store [`ASC_NUM_CH];

    // One word per channel, cleared so reads never return unknowns
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < `ASC_NUM_CH; i++) begin
                store[i] <= `ASC_RST_RES;
            end
        end else if (port.wr_en) begin
            store[port.wr_idx] <= port.wr_data;
        end
    end

    // Read word registered here so the bus sees it exactly one cycle later
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            port.rdata <= 32'h0000_0000;
        end else if (port.rd_en) begin
            port.rdata <= port.rd_res ? {16'h0000, store[port.rd_idx]} : port.reg_rdata;
        end
    end
endmodule : asc_res_mem

//--- testbench/asc_conv_model.sv
// Behavioural converter that answers each start pulse with a channel-coded result
`timescale 1ns/10ps
module asc_conv_model (
    input  wire logic        sys_clk_i,
    input  wire logic        conv_start_i,
    input  wire logic [4:0]  conv_chan_i,
    input  wire logic        slow_i,
    output logic             conv_done_o,
    output logic      [11:0] conv_data_o
);
    logic [3:0] wait_cnt;
    logic [4:0] chan;
    logic       busy;

    // Known state at time zero; the model has no reset of its own
    initial begin
        busy = 1'b0;
        wait_cnt = 4'h0;
        chan = 5'h00;
        conv_done_o = 1'b0;
        conv_data_o = 12'ha5a;
    end

    // One conversion at a time; slow mode stretches it so a stop can land mid-scan
    always @(posedge sys_clk_i) begin
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o; // Data is not held after done, so a late sample shows
        if (conv_start_i) begin
            busy <= 1'b1;
            chan <= conv_chan_i;
            wait_cnt <= slow_i ? 4'h7 : 4'h1;
        end else if (busy && wait_cnt == 4'h0) begin
            busy <= 1'b0;
            conv_done_o <= 1'b1;
            conv_data_o <= {chan, 7'h35};
        end else if (busy) begin
            wait_cnt <= wait_cnt - 4'h1;
        end
    end
endmodule : asc_conv_model

//--- testbench/test_adc_continuous_scan_ctrl.sv
// Self-checking testbench of the scan controller with a behavioural converter
`timescale 1ns/10ps
`include "asc_map.svh"
module test_adc_continuous_scan_ctrl;
    logic               sys_clk_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic [7:0]         addr_i    = 8'h00;
    logic [31:0]        wr_data_i = 32'h0000_0000;
    logic               wr_en_i   = 1'b0;
    logic               rd_en_i   = 1'b0;
    logic               hw_trig_i = 1'b0;
    logic               slow      = 1'b0;
    logic [31:0]        rd_data_o;
    logic               conv_start_o;
    logic               conv_done_i;
    logic               irq_o;
    logic [11:0]        conv_data_i;
    asc_pkg::asc_chan_t conv_chan_o;
    asc_pkg::asc_chan_t starts[$];
    logic [31:0]        rv;
    int                 fails     = 0;
    int                 cmp_count = 0;

    asc_scan_ctrl DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .hw_trig_i(hw_trig_i), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .irq_o(irq_o));
    asc_conv_model conv (.sys_clk_i(sys_clk_i), .conv_start_i(conv_start_o),
        .conv_chan_i(conv_chan_o), .slow_i(slow), .conv_done_o(conv_done_i),
        .conv_data_o(conv_data_i));

    always #20 sys_clk_i = ~sys_clk_i;

    // Log every channel launched, in launch order
    always @(posedge sys_clk_i) begin
        if (conv_start_o === 1'b1) begin
            starts.push_back(conv_chan_o);
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
    endtask : wr

    // Read data stand from the cycle after the strobe until the next read, so sample just past that edge
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_en_i <= 1'b0;
        #1 rv = rd_data_o;
    endtask : rd

    // Expected stored word; the model codes the channel into its result
    function automatic logic [31:0] res(input logic [4:0] ch, input logic left);
        res = left ? {16'h0000, ch, 7'h35, 4'h0} : {20'h00000, ch, 7'h35};
    endfunction : res

    task automatic wait_starts(input int n);
        int i;
        for (i = 0; i < 2000 && starts.size() < n; i++) begin
            @(posedge sys_clk_i);
        end
        chk(starts.size() >= n, 1'b1);
    endtask : wait_starts

    task automatic wait_idle();
        int i;
        for (i = 0; i < 200; i++) begin
            rd(`ASC_OFF_CTRL);
            if (rv[`ASC_BIT_START] === 1'b0) break;
        end
        chk(rv[`ASC_BIT_START], 1'b0);
    endtask : wait_idle

    task automatic pulse_trig();
        @(posedge sys_clk_i);
        hw_trig_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        hw_trig_i <= 1'b0;
    endtask : pulse_trig

    task automatic t_reset();
        rd(`ASC_OFF_CTRL);
        chk(rv, `ASC_RST_CTRL);
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h0000_0000);
        rd(`ASC_OFF_RES_LAST);
        chk(rv, 32'h0000_0000);
        rd(8'hfc);
        chk(rv, 32'h0000_0000);
        rd(`ASC_OFF_CLR);
        chk(rv, 32'h0000_0000);
        chk(irq_o, 1'b0);
        $display("test reset done");
    endtask : t_reset

    // Channels 0, 2 and 23 across both select registers, single scan with interrupt
    task automatic t_single();
        starts.delete();
        wr(`ASC_OFF_CHSEL_LO, 32'h0000_0005);
        wr(`ASC_OFF_CHSEL_HI, 32'h0000_0080);
        wr(`ASC_OFF_CTRL, 32'h0000_0003);
        wait_starts(3);
        wait_idle();
        chk(starts.size(), 3);
        chk(starts[0], 5'd0);
        chk(starts[1], 5'd2);
        chk(starts[2], 5'd23);
        rd(`ASC_OFF_RES_BASE);
        chk(rv, res(5'd0, 1'b0));
        rd(`ASC_OFF_RES_BASE + 8'h08);
        chk(rv, res(5'd2, 1'b0));
        rd(`ASC_OFF_RES_LAST);
        chk(rv, res(5'd23, 1'b0));
        rd(`ASC_OFF_RES_BASE + 8'h04);
        chk(rv, 32'h0000_0000);
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h0000_0001);
        chk(irq_o, 1'b1);
        $display("test single done");
    endtask : t_single

    // Clear the flag, then a scan with the interrupt masked and a late unmask
    task automatic t_flag();
        wr(`ASC_OFF_CLR, 32'h0000_0001);
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h0000_0000);
        chk(irq_o, 1'b0);
        wr(`ASC_OFF_CTRL, 32'h0000_0001);
        wait_starts(6);
        wait_idle();
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h0000_0001);
        chk(irq_o, 1'b0);
        wr(`ASC_OFF_IEN, 32'h0000_0001);
        rd(`ASC_OFF_IEN);
        chk(rv, 32'h0000_0001);
        chk(irq_o, 1'b1);
        $display("test flag done");
    endtask : t_flag

    // Continuous, left aligned, slow converter, flag cleared and stop mid-scan
    task automatic t_cont();
        starts.delete();
        slow <= 1'b1;
        wr(`ASC_OFF_CLR, 32'h0000_0001);
        wr(`ASC_OFF_CTRL, 32'h0000_002b);
        wait_starts(4);
        chk(starts[3], 5'd0);
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h0000_0001);
        rd(`ASC_OFF_CTRL);
        chk(rv[`ASC_BIT_BUSY], 1'b1);
        wr(`ASC_OFF_CLR, 32'h0000_0001);
        wait_starts(5);
        chk(starts[4], 5'd2);
        wr(`ASC_OFF_CTRL, 32'h0000_002a);
        repeat (40) @(posedge sys_clk_i);
        chk(starts.size(), 5);
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h0000_0000);
        rd(`ASC_OFF_CTRL);
        chk(rv[`ASC_BIT_BUSY], 1'b0);
        rd(`ASC_OFF_RES_LAST);
        chk(rv, res(5'd23, 1'b1));
        starts.delete();
        wr(`ASC_OFF_CTRL, 32'h0000_002b);
        wait_starts(1);
        chk(starts[0], 5'd0);
        wr(`ASC_OFF_CTRL, 32'h0000_0000);
        slow <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        $display("test continuous done");
    endtask : t_cont

    // The pin does nothing until the trigger enable is set as the last step
    task automatic t_trig();
        wr(`ASC_OFF_CLR, 32'h0000_0001);
        wr(`ASC_OFF_CTRL, 32'h0000_0002);
        starts.delete();
        pulse_trig();
        repeat (10) @(posedge sys_clk_i);
        chk(starts.size(), 0);
        wr(`ASC_OFF_CTRL, 32'h0000_0012);
        pulse_trig();
        wait_starts(3);
        wait_idle();
        chk(starts[0], 5'd0);
        chk(irq_o, 1'b1);
        $display("test trigger done");
    endtask : t_trig

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_single();
        t_flag();
        t_cont();
        t_trig();
        test_done();
    end

    // The whole run needs a few hundred cycles; far beyond that means a hang
    initial begin
        #(40 * 20000);
        fails++;
        test_done();
    end
endmodule : test_adc_continuous_scan_ctrl
